//--- lcd_drive_ctrl.sv
// Segment display controller: timing, waveforms, pixel store, sleep, pins
//
// Operation
// - A set segment enable bit turns its pin into a segment driver.
// - Set segment enable overrides pin direction; clear leaves direction alone.
// - After reset every segment enable is clear, pins stay digital I/O.
// - Each pixel bit drives one crossing; unused bits are plain storage.
// - Frame rate is clock over k times (prescale value plus one) times 32 times commons.
// - Display clock comes from system clock over 256, crystal or slow oscillator.
// - Waveform keeps zero DC; Type-A per slot, Type-B over two frames.
// - Set pixel gets the higher RMS level, clear pixel the lower one.
// - Interrupt flag rises when the active flag falls at shutdown.
// - Frame interrupt set after pixel fetch, fixed lead before frame boundary.
// - Type-B interrupts on whole phase pairs; disabled writes dropped, error set.
// - No frame interrupts with Type-A or with Type-B static drive.
// - Sleep with stop select set stops at once, all outputs at ground.
// - Clearing enable finishes the frame, drops active, flags, frees the pins.
// - Sleep, stop select clear, system clock: module halts, pins hold pattern.
// - Sleep on oscillator clock keeps displaying; pixel data frozen until wake.
// - Sleeping with interrupt enabled and frame interrupts: wake at frame boundary.
// - Backplane count select picks one to four backplanes; unused ones idle.
// - Waveform type select one means Type-B, zero means Type-A.
`timescale 1ns/1ns
module lcd_drive_ctrl (
  input  wire logic                                  mclk_in,
  input  wire logic                                  rst_b_in,
  input  wire logic                                  module_enable_bit_in,
  input  wire logic                                  sleep_stop_select_in,
  input  wire logic                                  waveform_type_select_in,
  input  wire logic [1:0]                            backplane_count_select_in,
  input  wire logic [1:0]                            clock_select_in,
  input  wire logic [lcd_pkg::PSC_W-1:0]             frame_prescale_value_in,
  input  wire logic                                  display_irq_enable_in,
  input  wire logic                                  display_irq_clear_in,
  input  wire logic                                  write_error_clear_in,
  input  wire logic                                  cpu_sleep_in,
  input  wire logic                                  secondary_crystal_clock_in,
  input  wire logic                                  low_freq_internal_clock_in,
  input  wire logic [lcd_pkg::SEG_COUNT-1:0]         segment_pin_enable_regs_in,
  input  wire logic [lcd_pkg::SEG_COUNT-1:0]         pin_direction_reg_in,
  input  wire logic                                  pixel_wr_in,
  input  wire logic [lcd_pkg::ROW_W-1:0]             pixel_addr_in,
  input  wire logic [lcd_pkg::SEG_COUNT-1:0]         pixel_wdata_in,
  output logic [lcd_pkg::SEG_COUNT-1:0]              pixel_rdata_out,
  output logic                                       module_active_flag_out,
  output logic                                       write_error_flag_out,
  output logic                                       display_irq_flag_out,
  output logic                                       wake_out,
  output logic [lcd_pkg::SEG_COUNT-1:0]              segment_mode_out,
  output logic [lcd_pkg::SEG_COUNT-1:0]              pin_direction_eff_out,
  output logic [lcd_pkg::COM_COUNT-1:0]              backplane_mode_out,
  output logic [lcd_pkg::COM_COUNT*lcd_pkg::LVL_W-1:0] backplane_drive_out,
  output logic [lcd_pkg::SEG_COUNT*lcd_pkg::LVL_W-1:0] pixel_column_drive_out
);

  lcd_pkg::run_state_type state_q;
  lcd_pkg::run_state_type state_d;

  logic [lcd_pkg::SEG_COUNT-1:0] pix_q [lcd_pkg::COM_COUNT];
  logic [lcd_pkg::SEG_COUNT-1:0] shadow_q [lcd_pkg::COM_COUNT];
  logic [lcd_pkg::PSC_W-1:0]     psc_q;
  logic [lcd_pkg::SUB_W-1:0]     sub_q;
  logic [lcd_pkg::ROW_W-1:0]     com_q;
  logic                          pair_q;
  logic                          win_q;
  logic                          write_error_flag_q;
  logic                          irq_q;
  logic                          wake_q;

  logic                          tick;
  logic                          active;
  logic                          halt;
  logic                          stop_now;
  logic                          run_en;
  logic                          step;
  logic                          psc_wrap;
  logic                          slot_end;
  logic                          frame_end;
  logic                          fetch_done;
  logic                          frame_irq_on;
  logic                          shutdown_evt;
  logic                          wr_allowed;
  logic                          phase;
  logic [lcd_pkg::SUB_W-1:0]     slot_last;
  logic [lcd_pkg::SEG_COUNT-1:0] cur_row;

  lcd_tick_gen u_tick (
    .mclk_in                    (mclk_in),
    .rst_b_in                   (rst_b_in),
    .clock_select_in            (clock_select_in),
    .secondary_crystal_clock_in (secondary_crystal_clock_in),
    .low_freq_internal_clock_in (low_freq_internal_clock_in),
    .tick_out                   (tick)
  );

  assign active   = (state_q != lcd_pkg::ST_IDLE);
  assign stop_now = cpu_sleep_in & sleep_stop_select_in;
  // System-clock source cannot run in sleep, whatever the stop select says
  assign halt     = cpu_sleep_in & (sleep_stop_select_in
                    | (clock_select_in == lcd_pkg::CLK_SYS));
  assign run_en   = active & ~halt;
  assign step     = run_en & tick;

  // Frame interrupts exist only for Type-B multiplexed drive
  assign frame_irq_on = waveform_type_select_in
                        & (backplane_count_select_in != lcd_pkg::MUX_STATIC);

  always_comb
  begin
    unique case (backplane_count_select_in)
      lcd_pkg::MUX_STATIC: slot_last = lcd_pkg::SLOT_LAST_STATIC;
      lcd_pkg::MUX_HALF:   slot_last = lcd_pkg::SLOT_LAST_HALF;
      default:             slot_last = lcd_pkg::SLOT_LAST_MULTI;
    endcase
  end

  assign psc_wrap  = step & (psc_q == frame_prescale_value_in);
  assign slot_end  = psc_wrap & (sub_q == slot_last);
  assign frame_end = slot_end & (com_q == backplane_count_select_in);
  // Last slot of a frame pair starts: the data for the pair is consumed
  assign fetch_done = slot_end & pair_q
                      & (com_q == backplane_count_select_in - 2'h1);
  assign shutdown_evt = (state_q == lcd_pkg::ST_STOPPING) & frame_end;

  // Prescaler
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      psc_q <= '0;
    else if (!active || psc_wrap)
      psc_q <= '0;
    else if (step)
      psc_q <= psc_q + 4'h1;
  end

  // Ticks within one backplane slot
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      sub_q <= '0;
    else if (!active || slot_end)
      sub_q <= '0;
    else if (psc_wrap)
      sub_q <= sub_q + 7'h1;
  end

  // Backplane slot and frame parity
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      com_q  <= '0;
      pair_q <= 1'b0;
    end
    else if (!active)
    begin
      com_q  <= '0;
      pair_q <= 1'b0;
    end
    else if (frame_end)
    begin
      com_q  <= '0;
      pair_q <= ~pair_q;
    end
    else if (slot_end)
      com_q <= com_q + 2'h1;
  end

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      lcd_pkg::ST_IDLE:
        if (module_enable_bit_in)
          state_d = lcd_pkg::ST_RUN;
      lcd_pkg::ST_RUN:
        if (!module_enable_bit_in)
          state_d = lcd_pkg::ST_STOPPING;
      lcd_pkg::ST_STOPPING:
        if (frame_end)
          state_d = lcd_pkg::ST_IDLE;
      default:
        state_d = lcd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      state_q <= lcd_pkg::ST_IDLE;
    else
      state_q <= state_d;
  end

  // Write window runs from the frame interrupt to the pair boundary
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      win_q <= 1'b0;
    else if (!active || frame_end)
      win_q <= 1'b0;
    else if (fetch_done)
      win_q <= 1'b1;
  end

  // Sleep freezes data; Type-B multiplexed only accepts inside the window
  assign wr_allowed = ~cpu_sleep_in
                      & (~active | ~frame_irq_on | win_q);

  generate
    for (genvar r = 0; r < lcd_pkg::COM_COUNT; r++)
    begin : g_row
      always_ff @(posedge mclk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
          pix_q[r] <= lcd_pkg::PIX_RESET;
        else if (pixel_wr_in && wr_allowed
                 && (pixel_addr_in == r[lcd_pkg::ROW_W-1:0]))
          pix_q[r] <= pixel_wdata_in;
      end

      // Type-B multiplexed reloads only at a pair end to keep frames balanced
      always_ff @(posedge mclk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
          shadow_q[r] <= lcd_pkg::PIX_RESET;
        else if (!active || (frame_end && (pair_q || !frame_irq_on)))
          shadow_q[r] <= pix_q[r];
      end
    end
  endgenerate

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      pixel_rdata_out <= '0;
    else
      pixel_rdata_out <= pix_q[pixel_addr_in];
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      write_error_flag_q <= 1'b0;
    else if (pixel_wr_in && !wr_allowed && !cpu_sleep_in)
      write_error_flag_q <= 1'b1;
    else if (write_error_clear_in)
      write_error_flag_q <= 1'b0;
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      irq_q <= 1'b0;
    else if (shutdown_evt || (fetch_done && frame_irq_on))
      irq_q <= 1'b1;
    else if (display_irq_clear_in)
      irq_q <= 1'b0;
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      wake_q <= 1'b0;
    else
      wake_q <= cpu_sleep_in & display_irq_enable_in
                & frame_irq_on & frame_end;
  end

  assign module_active_flag_out = active;
  assign write_error_flag_out   = write_error_flag_q;
  assign display_irq_flag_out   = irq_q;
  assign wake_out               = wake_q;

  // Type-A flips halfway through each slot, Type-B on each frame
  assign phase   = waveform_type_select_in ? pair_q
                   : (sub_q > (slot_last >> 1));
  assign cur_row = shadow_q[com_q];

  generate
    for (genvar c = 0; c < lcd_pkg::COM_COUNT; c++)
    begin : g_com
      logic used;
      logic [lcd_pkg::LVL_W-1:0] lvl;

      assign used = (c[1:0] <= backplane_count_select_in);
      assign backplane_mode_out[c] = active & used;

      always_comb
      begin
        if (!used)
          lvl = lcd_pkg::LVL_V0;
        else if (com_q == c[lcd_pkg::ROW_W-1:0])
          lvl = phase ? lcd_pkg::LVL_V3 : lcd_pkg::LVL_V0;
        else
          lvl = phase ? lcd_pkg::LVL_V1 : lcd_pkg::LVL_V2;
      end

      always_ff @(posedge mclk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
          backplane_drive_out[c*lcd_pkg::LVL_W +: lcd_pkg::LVL_W] <= lcd_pkg::LVL_V0;
        else if (!active || stop_now)
          backplane_drive_out[c*lcd_pkg::LVL_W +: lcd_pkg::LVL_W] <= lcd_pkg::LVL_V0;
        else if (!halt)
          backplane_drive_out[c*lcd_pkg::LVL_W +: lcd_pkg::LVL_W] <= lvl;
      end
    end

    for (genvar s = 0; s < lcd_pkg::SEG_COUNT; s++)
    begin : g_seg
      logic [lcd_pkg::LVL_W-1:0] lvl;

      assign segment_mode_out[s] = active & segment_pin_enable_regs_in[s];
      // Segment drivers are outputs regardless of the direction setting
      assign pin_direction_eff_out[s] = segment_mode_out[s] ? 1'b0
                                        : pin_direction_reg_in[s];

      always_comb
      begin
        if (backplane_count_select_in == lcd_pkg::MUX_STATIC)
        begin
          if (cur_row[s])
            lvl = phase ? lcd_pkg::LVL_V0 : lcd_pkg::LVL_V3;
          else
            lvl = phase ? lcd_pkg::LVL_V3 : lcd_pkg::LVL_V0;
        end
        else if (cur_row[s])
          lvl = phase ? lcd_pkg::LVL_V0 : lcd_pkg::LVL_V3;
        else
          lvl = phase ? lcd_pkg::LVL_V2 : lcd_pkg::LVL_V1;
      end

      always_ff @(posedge mclk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
          pixel_column_drive_out[s*lcd_pkg::LVL_W +: lcd_pkg::LVL_W] <= lcd_pkg::LVL_V0;
        else if (!active || stop_now)
          pixel_column_drive_out[s*lcd_pkg::LVL_W +: lcd_pkg::LVL_W] <= lcd_pkg::LVL_V0;
        else if (!halt)
          pixel_column_drive_out[s*lcd_pkg::LVL_W +: lcd_pkg::LVL_W] <= lvl;
      end
    end
  endgenerate

endmodule : lcd_drive_ctrl

//--- lcd_pkg.sv
// Shared constants and types for the segment display controller
package lcd_pkg;

  localparam int SEG_COUNT = 27;
  localparam int COM_COUNT = 4;
  localparam int ROW_W     = 2;
  localparam int LVL_W     = 2;
  localparam int PSC_W     = 4;
  localparam int SUB_W     = 7;

  localparam logic [1:0] MUX_STATIC  = 2'h0;
  localparam logic [1:0] MUX_HALF    = 2'h1;
  localparam logic [1:0] MUX_THIRD   = 2'h2;
  localparam logic [1:0] MUX_QUARTER = 2'h3;

  localparam logic [1:0] CLK_SYS       = 2'h0;
  localparam logic [1:0] CLK_SECONDARY = 2'h1;
  localparam logic [1:0] CLK_LOWFREQ   = 2'h2;

  localparam int         SYS_DIV_W = 8;
  localparam logic [7:0] SYS_DIV_LAST = 8'hff;

  // Slot length in prescaled ticks is 32 times k, minus one for the compare
  localparam logic [SUB_W-1:0] SLOT_LAST_STATIC = 7'h7f;
  localparam logic [SUB_W-1:0] SLOT_LAST_HALF   = 7'h3f;
  localparam logic [SUB_W-1:0] SLOT_LAST_MULTI  = 7'h1f;

  localparam logic [LVL_W-1:0] LVL_V0 = 2'h0;
  localparam logic [LVL_W-1:0] LVL_V1 = 2'h1;
  localparam logic [LVL_W-1:0] LVL_V2 = 2'h2;
  localparam logic [LVL_W-1:0] LVL_V3 = 2'h3;

  localparam logic [SEG_COUNT-1:0] PIX_RESET = 27'h0;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_RUN      = 2'b01,
    ST_STOPPING = 2'b10
  } run_state_type;

endpackage : lcd_pkg

//--- lcd_tick_gen.sv
// Display clock source selection and tick generation
`timescale 1ns/1ns
module lcd_tick_gen (
  input  wire logic       mclk_in,
  input  wire logic       rst_b_in,
  input  wire logic [1:0] clock_select_in,
  input  wire logic       secondary_crystal_clock_in,
  input  wire logic       low_freq_internal_clock_in,
  output logic            tick_out
);

  logic [2:0] sec_sync_q;
  logic [2:0] lfo_sync_q;
  logic [lcd_pkg::SYS_DIV_W-1:0] sys_div_q;
  logic sec_rise;
  logic lfo_rise;
  logic sys_wrap;

  // Stage 0 feeds only stage 1; edges are taken from stages 1 and 2
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sec_sync_q <= 3'h0;
      lfo_sync_q <= 3'h0;
    end
    else
    begin
      sec_sync_q <= {sec_sync_q[1:0], secondary_crystal_clock_in};
      lfo_sync_q <= {lfo_sync_q[1:0], low_freq_internal_clock_in};
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      sys_div_q <= '0;
    else
      sys_div_q <= sys_div_q + 8'h1;
  end

  assign sec_rise = sec_sync_q[1] & ~sec_sync_q[2];
  assign lfo_rise = lfo_sync_q[1] & ~lfo_sync_q[2];
  assign sys_wrap = (sys_div_q == lcd_pkg::SYS_DIV_LAST);

  always_comb
  begin
    unique case (clock_select_in)
      lcd_pkg::CLK_SYS:       tick_out = sys_wrap;
      lcd_pkg::CLK_SECONDARY: tick_out = sec_rise;
      default:                tick_out = lfo_rise;
    endcase
  end

endmodule : lcd_tick_gen

//--- lcd_drive_chk.sv
// Port-level assertions for the segment display controller
`timescale 1ns/1ns
module lcd_drive_chk (
  input wire logic                                    mclk_in,
  input wire logic                                    rst_b_in,
  input wire logic                                    module_enable_bit_in,
  input wire logic                                    sleep_stop_select_in,
  input wire logic                                    waveform_type_select_in,
  input wire logic [1:0]                              backplane_count_select_in,
  input wire logic [1:0]                              clock_select_in,
  input wire logic                                    display_irq_enable_in,
  input wire logic                                    cpu_sleep_in,
  input wire logic [lcd_pkg::SEG_COUNT-1:0]           segment_pin_enable_regs_in,
  input wire logic [lcd_pkg::SEG_COUNT-1:0]           pin_direction_reg_in,
  input wire logic                                    pixel_wr_in,
  input wire logic                                    module_active_flag_out,
  input wire logic                                    write_error_flag_out,
  input wire logic                                    display_irq_flag_out,
  input wire logic                                    wake_out,
  input wire logic [lcd_pkg::SEG_COUNT-1:0]           segment_mode_out,
  input wire logic [lcd_pkg::SEG_COUNT-1:0]           pin_direction_eff_out,
  input wire logic [lcd_pkg::COM_COUNT-1:0]           backplane_mode_out,
  input wire logic [lcd_pkg::COM_COUNT*lcd_pkg::LVL_W-1:0] backplane_drive_out,
  input wire logic [lcd_pkg::SEG_COUNT*lcd_pkg::LVL_W-1:0] pixel_column_drive_out
);
  logic       multi;
  logic [3:0] used;
  assign multi = waveform_type_select_in && (backplane_count_select_in != 2'h0);
  assign used  = 4'hf >> (2'h3 - backplane_count_select_in);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  seg_select_a: assert property (
    segment_mode_out == (module_active_flag_out ? segment_pin_enable_regs_in : '0))
    else $error("segment mode differs from enables");
  dir_override_a: assert property (
    pin_direction_eff_out == (pin_direction_reg_in & ~segment_mode_out))
    else $error("pin direction not overridden");
  active_rise_a: assert property (
    !module_active_flag_out && module_enable_bit_in && !cpu_sleep_in |=> module_active_flag_out)
    else $error("active flag did not rise");
  shutdown_irq_a: assert property (
    $fell(module_active_flag_out) |-> display_irq_flag_out && !$past(module_enable_bit_in))
    else $error("shutdown without flag or while enabled");
  bp_used_a: assert property (
    backplane_mode_out == (module_active_flag_out ? used : 4'h0))
    else $error("backplane usage wrong");
  stop_ground_a: assert property (
    (cpu_sleep_in && sleep_stop_select_in) [*2] |-> backplane_drive_out == '0
      && pixel_column_drive_out == '0) else $error("outputs not grounded in sleep");
  halt_hold_a: assert property (
    (cpu_sleep_in && !sleep_stop_select_in && clock_select_in == lcd_pkg::CLK_SYS) [*3]
      |-> $stable(backplane_drive_out) && $stable(pixel_column_drive_out))
    else $error("outputs moved while halted");
  no_frame_irq_a: assert property (
    $rose(display_irq_flag_out) && !multi |-> $fell(module_active_flag_out))
    else $error("frame flag outside frame mode");
  write_error_flag_cause_a: assert property (
    $rose(write_error_flag_out) |-> $past(pixel_wr_in && module_active_flag_out && multi
      && !cpu_sleep_in)) else $error("write error without refused write");
  wake_cause_a: assert property (
    wake_out |-> $past(cpu_sleep_in && display_irq_enable_in && multi))
    else $error("wake without cause");
endmodule : lcd_drive_chk

bind lcd_drive_ctrl lcd_drive_chk u_chk (.*);

//--- lcd_glass_model.sv
// Passive glass model: voltage across two pixels on the first backplane
`timescale 1ns/1ns
module lcd_glass_model (
  input  wire logic       mclk_in,
  input  wire logic       clr_in,
  input  wire logic       en_in,
  input  wire logic [1:0] bp_in,
  input  wire logic [1:0] seg_on_in,
  input  wire logic [1:0] seg_off_in,
  output int              dc_out,
  output int              sq_on_out,
  output int              sq_off_out
);
  int d_on;
  int d_off;
  assign d_on  = int'(bp_in) - int'(seg_on_in);
  assign d_off = int'(bp_in) - int'(seg_off_in);
  always @(posedge mclk_in)
  begin
    if (clr_in)
    begin
      dc_out     <= 0;
      sq_on_out  <= 0;
      sq_off_out <= 0;
    end
    else if (en_in)
    begin
      dc_out     <= dc_out + d_on;
      sq_on_out  <= sq_on_out + d_on * d_on;
      sq_off_out <= sq_off_out + d_off * d_off;
    end
  end
endmodule : lcd_glass_model

//--- test_segment_lcd_drive_control.sv
// Self-checking bench for the segment display controller
`timescale 1ns/1ns
module test_segment_lcd_drive_control;
  logic mclk_in, rst_b_in, module_enable_bit_in, sleep_stop_select_in;
  logic waveform_type_select_in, display_irq_enable_in, display_irq_clear_in;
  logic write_error_clear_in, cpu_sleep_in, pixel_wr_in, clr_q;
  logic secondary_crystal_clock_in, low_freq_internal_clock_in;
  logic [1:0] backplane_count_select_in, clock_select_in, pixel_addr_in, lf_q;
  logic [3:0] frame_prescale_value_in, backplane_mode_out;
  logic [26:0] segment_pin_enable_regs_in, pin_direction_reg_in, pixel_wdata_in;
  logic [26:0] pixel_rdata_out, segment_mode_out, pin_direction_eff_out;
  logic module_active_flag_out, write_error_flag_out, display_irq_flag_out, wake_out;
  logic [7:0]  backplane_drive_out;
  logic [53:0] pixel_column_drive_out, snap;
  int errors, checks, cyc, t0, k, slot, dc, sq_on, sq_off;

  lcd_drive_ctrl u_dut (.*);
  lcd_glass_model u_glass (.mclk_in(mclk_in), .clr_in(clr_q), .en_in(backplane_mode_out[0]),
    .bp_in(backplane_drive_out[1:0]), .seg_on_in(pixel_column_drive_out[1:0]),
    .seg_off_in(pixel_column_drive_out[3:2]), .dc_out(dc), .sq_on_out(sq_on),
    .sq_off_out(sq_off));

  always #25 mclk_in = ~mclk_in;
  // Slow sources kept short so frames stay a few hundred cycles
  always @(posedge mclk_in)
  begin
    secondary_crystal_clock_in <= ~secondary_crystal_clock_in;
    lf_q <= lf_q + 2'h1;
    low_freq_internal_clock_in <= lf_q[1];
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : tick

  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic pix_wr(input logic [1:0] a, input logic [26:0] d);
    tick(1);
    pixel_wr_in <= 1'b1;
    pixel_addr_in <= a;
    pixel_wdata_in <= d;
    tick(1);
    pixel_wr_in <= 1'b0;
  endtask : pix_wr

  task automatic pix_rd(input logic [1:0] a, input logic [26:0] exp);
    tick(1);
    pixel_addr_in <= a;
    tick(2);
    #1;
    check("pixel_rdata", exp, pixel_rdata_out);
  endtask : pix_rd

  task automatic clr(input logic irq, input logic write_error_flag);
    tick(1);
    display_irq_clear_in <= irq;
    write_error_clear_in <= write_error_flag;
    tick(1);
    display_irq_clear_in <= 1'b0;
    write_error_clear_in <= 1'b0;
  endtask : clr

  task automatic wait_on(input int which, input int limit);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < limit)
    begin
      @(posedge mclk_in);
      #1;
      n++;
      hit = (which == 0) ? display_irq_flag_out === 1'b1 :
            (which == 1) ? module_active_flag_out === 1'b0 : wake_out === 1'b1;
    end
    check("wait", 1'b1, hit);
  endtask : wait_on

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    {mclk_in, rst_b_in, module_enable_bit_in, sleep_stop_select_in, cpu_sleep_in} = '0;
    {waveform_type_select_in, display_irq_enable_in, display_irq_clear_in} = '0;
    {write_error_clear_in, pixel_wr_in, pixel_addr_in, pixel_wdata_in, lf_q} = '0;
    {secondary_crystal_clock_in, low_freq_internal_clock_in, cyc, errors, checks} = '0;
    backplane_count_select_in = 2'h3;
    clock_select_in = lcd_pkg::CLK_SECONDARY;
    frame_prescale_value_in = 4'h0;
    segment_pin_enable_regs_in = 27'h0f0f0f;
    pin_direction_reg_in = 27'h5a5a5a5;
    clr_q = 1'b1;
    tick(10);
    rst_b_in <= 1'b1;
    #1;
    check("seg_mode", 27'h0, segment_mode_out);
    check("pin_dir", 27'h5a5a5a5, pin_direction_eff_out);
    pix_wr(2'h2, 27'h4000001);
    pix_wr(2'h3, 27'h2aaaaaa);
    pix_rd(2'h2, 27'h4000001);
    pix_rd(2'h3, 27'h2aaaaaa);
    pix_wr(2'h0, 27'h1);
    tick(1);
    clr_q <= 1'b0;
    module_enable_bit_in <= 1'b1;
    tick(1);
    #1;
    check("active", 1'b1, module_active_flag_out);
    check("seg_mode", 27'h0f0f0f, segment_mode_out);
    check("pin_dir", 27'h5a5a5a5 & ~27'h0f0f0f, pin_direction_eff_out);
    check("bp_mode", 4'hf, backplane_mode_out);
    pix_wr(2'h0, 27'h1);
    tick(1100);
    #1;
    check("write_error_flag", 1'b0, write_error_flag_out);
    check("irq", 1'b0, display_irq_flag_out);
    tick(1);
    module_enable_bit_in <= 1'b0;
    tick(3);
    #1;
    check("active", 1'b1, module_active_flag_out);
    wait_on(1, 400);
    check("irq", 1'b1, display_irq_flag_out);
    check("seg_mode", 27'h0, segment_mode_out);
    check("rms", 1'b1, sq_on > sq_off);
    check("dc", 1'b1, dc <= 8 && dc >= -8);
    clr(1'b1, 1'b0);
    for (int m = 1; m < 4; m++)
    begin
      k = (m == 1) ? 2 : 1;
      slot = 128 * k;
      tick(1);
      backplane_count_select_in <= 2'(m);
      frame_prescale_value_in <= 4'h1;
      waveform_type_select_in <= 1'b1;
      module_enable_bit_in <= 1'b1;
      tick(1);
      #1;
      check("bp_mode", 4'hf >> (3 - m), backplane_mode_out);
      wait_on(0, 5000);
      t0 = cyc;
      clr(1'b1, 1'b0);
      wait_on(0, 3000);
      check("pair", 2 * slot * (m + 1), cyc - t0);
      pix_wr(2'h0, 27'h1);
      tick(1);
      #1;
      check("write_error_flag", 1'b0, write_error_flag_out);
      tick(slot);
      pix_wr(2'h0, 27'h2);
      tick(1);
      #1;
      check("write_error_flag", 1'b1, write_error_flag_out);
      clr(1'b0, 1'b1);
      tick(1);
      #1;
      check("write_error_flag", 1'b0, write_error_flag_out);
      tick(1);
      module_enable_bit_in <= 1'b0;
      wait_on(1, 3000);
      clr(1'b1, 1'b0);
    end
    tick(1);
    backplane_count_select_in <= 2'h0;
    frame_prescale_value_in <= 4'h0;
    module_enable_bit_in <= 1'b1;
    tick(800);
    #1;
    check("irq", 1'b0, display_irq_flag_out);
    tick(1);
    cpu_sleep_in <= 1'b1;
    sleep_stop_select_in <= 1'b1;
    tick(3);
    #1;
    check("drive", 62'h0, {backplane_drive_out, pixel_column_drive_out});
    tick(1);
    sleep_stop_select_in <= 1'b0;
    cpu_sleep_in <= 1'b0;
    clock_select_in <= lcd_pkg::CLK_SYS;
    tick(20);
    cpu_sleep_in <= 1'b1;
    tick(3);
    #1;
    snap = pixel_column_drive_out;
    tick(1);
    // Off pixels would change level if the halted drivers still followed the mode
    backplane_count_select_in <= 2'h1;
    tick(299);
    #1;
    check("hold", snap, pixel_column_drive_out);
    tick(1);
    cpu_sleep_in <= 1'b0;
    backplane_count_select_in <= 2'h0;
    clock_select_in <= lcd_pkg::CLK_SECONDARY;
    module_enable_bit_in <= 1'b0;
    wait_on(1, 1000);
    clr(1'b1, 1'b0);
    pix_wr(2'h1, 27'h3);
    tick(1);
    clock_select_in <= lcd_pkg::CLK_LOWFREQ;
    backplane_count_select_in <= 2'h3;
    display_irq_enable_in <= 1'b1;
    module_enable_bit_in <= 1'b1;
    wait_on(0, 2500);
    clr(1'b1, 1'b0);
    tick(1);
    cpu_sleep_in <= 1'b1;
    pix_wr(2'h1, 27'h7ffffff);
    tick(1);
    #1;
    check("write_error_flag", 1'b0, write_error_flag_out);
    wait_on(2, 1200);
    tick(1);
    cpu_sleep_in <= 1'b0;
    pix_rd(2'h1, 27'h3);
    tick(1);
    module_enable_bit_in <= 1'b0;
    wait_on(1, 1200);
    tick(1);
    cpu_sleep_in <= 1'b1;
    tick(2);
    #1;
    check("drive", 62'h0, {backplane_drive_out, pixel_column_drive_out});
    tally_and_finish();
  end
endmodule : test_segment_lcd_drive_control
